// >>> pkg/dlnb2_pkg.sv
// Shared constants and types of the channel-2 serial register block
package dlnb2_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TONE_HZ = 22_000;
   localparam int TONE_DIV_W = 10;
   localparam logic [TONE_DIV_W-1:0] TONE_HALF =
      TONE_DIV_W'(CLK_HZ / (2 * TONE_HZ));

   // ==========================================================
   // Bus address and register selectors
   localparam logic [4:0] SLV_ADDR_HI = 5'h02;
   localparam logic [2:0] SEL_TONE = 3'h5;
   localparam logic [2:0] SEL_CMD = 3'h6;
   localparam logic [2:0] SEL_CTL = 3'h7;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;

   // ==========================================================
   // Field positions in the stored registers, and of the enable bit in a written byte
   localparam int TONE_ENT = 2;
   localparam int TONE_MSEL = 1;
   localparam int TONE_TTH = 0;
   localparam int CMD_DCL = 4;
   localparam int CMD_VSPEN = 3;
   localparam int CMD_ILR = 2;
   localparam int CMD_ILH = 1;
   localparam int CMD_ILL = 0;
   localparam int CTL_EN = 2;
   localparam int CTL_VTOP = 1;
   localparam int CTL_VBOT = 0;
   localparam int WR_EN_POS = 4;

   // ==========================================================
   // Reset values and output codes
   localparam logic [2:0] TONE_RST = 3'h0;
   localparam logic [4:0] CMD_RST = 5'h00;
   localparam logic [2:0] CTL_RST = 3'h0;
   localparam logic [2:0] ILIM_275 = 3'h0;
   localparam logic [2:0] ILIM_350 = 3'h1;
   localparam logic [2:0] ILIM_800 = 3'h4;
   localparam logic [1:0] VOUT_13 = 2'h0;
   localparam logic [1:0] VOUT_14 = 2'h1;
   localparam logic [1:0] VOUT_18 = 2'h2;
   localparam logic [1:0] VOUT_19 = 2'h3;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_AACK = 3'b010,
      S_WDAT = 3'b011,
      S_WACK = 3'b100,
      S_RDAT = 3'b101,
      S_RACK = 3'b110
   } dlnb2_bus_t;

   typedef struct packed {
      logic overtemp_flag;
      logic tone_seen_ch2;
      logic tone_seen_ch1;
      logic voltage_diag_ch2;
      logic voltage_diag_ch1;
      logic current_diag_ch2;
      logic current_diag_ch1;
   } dlnb2_diag_t;

   typedef struct packed {
      logic boost_en;
      logic linreg_en;
      logic [1:0] vout_sel;
      logic [2:0] ilim_sel;
      logic dyn_limit_en;
   } dlnb2_pwr_t;

   typedef struct packed {
      dlnb2_bus_t bus;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rw;
      logic mack;
      logic [1:0] rd_idx;
      logic sda_oe;
      logic scl_d;
      logic sda_d;
      logic [2:0] tone_reg;
      logic [4:0] cmd_reg;
      logic [2:0] ctl_reg;
      logic [TONE_DIV_W-1:0] div;
      logic tone;
      logic tone_out;
      logic det_lvl;
      dlnb2_pwr_t pwr;
   } dlnb2_state_t;

endpackage

// >>> core/dlnb2_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs
module dlnb2_sync #(
   parameter int W = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } dlnb2_sync_t;

   dlnb2_sync_t st_r;
   dlnb2_sync_t st_nxt;

   // ==========================================================
   // First stage feeds only the second stage
   always_comb begin
      st_nxt.meta = async_i;
      st_nxt.stab = st_r.meta;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stab;
endmodule

// >>> core/dlnb2_regs.sv
// Channel-2 serial-bus register slave with tone and supply control
module dlnb2_regs
   import dlnb2_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_strap_lo_i,
   input wire logic addr_strap_hi_i,
   input wire logic power_ok_i,
   input wire logic ext_mod_in_ch2_i,
   input wire logic hi_volt_pin_ch2_i,
   input wire logic tone_tx_pin_ch2_i,
   input wire dlnb2_diag_t diag_i,
   output dlnb2_pwr_t pwr_o,
   output logic tone_ch2_o,
   output logic tone_detect_level_ch2_o
);
   localparam int NSYNC = 15;

   dlnb2_state_t st_r;
   dlnb2_state_t st_nxt;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] syn;
   dlnb2_diag_t diag_s;
   logic scl_s;
   logic sda_s;
   logic ext_s;
   logic pin_s;
   logic txt_s;
   logic pg_s;
   logic strap_lo_s;
   logic strap_hi_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [7:0] rb;

   // ==========================================================
   // Input synchronisation
   // Every pin input, the diagnostics included, comes from outside
   assign raw = {diag_i, scl_i, sda_i, ext_mod_in_ch2_i,
                 hi_volt_pin_ch2_i, tone_tx_pin_ch2_i, power_ok_i,
                 addr_strap_lo_i, addr_strap_hi_i};

   dlnb2_sync #(
      .W(NSYNC)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i(raw),
      .sync_o(syn)
   );

   assign {diag_s, scl_s, sda_s, ext_s, pin_s, txt_s, pg_s,
           strap_lo_s, strap_hi_s} = syn;

   // ==========================================================
   // Read-back byte selection
   // Byte order per read: tone, command, control, diagnostics
   function automatic logic [7:0] rd_byte(
      input logic [1:0] idx,
      input dlnb2_state_t s,
      input dlnb2_diag_t d
   );
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         2'h0: b = {SEL_TONE, s.tone_reg, 2'h0};
         2'h1: b = {SEL_CMD, s.cmd_reg};
         2'h2: b = {SEL_CTL, s.ctl_reg[CTL_EN], 2'h0,
                    s.ctl_reg[CTL_VTOP], s.ctl_reg[CTL_VBOT]};
         default: b = {1'b0, d};
      endcase
      return b;
   endfunction

   assign rb = rd_byte(st_r.rd_idx, st_r, diag_s);

   // ==========================================================
   // Bus edge and condition detection on synchronised lines
   assign rise = scl_s & ~st_r.scl_d;
   assign fall = ~scl_s & st_r.scl_d;
   assign start = scl_s & st_r.scl_d & st_r.sda_d & ~sda_s;
   assign stop = scl_s & st_r.scl_d & ~st_r.sda_d & sda_s;

   // ==========================================================
   // Next-state logic: tone, power controls and bus engine
   always_comb begin
      st_nxt = st_r;
      st_nxt.scl_d = scl_s;
      st_nxt.sda_d = sda_s;

      // Free-running 22 kHz square wave from the system clock
      if (st_r.div == TONE_HALF - 10'h001) begin
         st_nxt.div = '0;
         st_nxt.tone = ~st_r.tone;
      end else begin
         st_nxt.div = st_r.div + 10'h001;
      end

      // Tone source follows the tone register mode
      case ({st_r.tone_reg[TONE_ENT], st_r.tone_reg[TONE_MSEL]})
         2'b00: st_nxt.tone_out = st_r.tone & ext_s;
         2'b01: st_nxt.tone_out = ext_s;
         2'b10: st_nxt.tone_out = st_r.tone;
         default: st_nxt.tone_out = st_r.tone;
      endcase
      // Pin and bit are ORed, so either can raise the level
      st_nxt.det_lvl = st_r.tone_reg[TONE_TTH] | txt_s;

      // Stage enables come from the enable bit alone
      st_nxt.pwr.boost_en = st_r.ctl_reg[CTL_EN];
      st_nxt.pwr.linreg_en = st_r.ctl_reg[CTL_EN];
      st_nxt.pwr.dyn_limit_en = ~st_r.cmd_reg[CMD_DCL];
      if (!st_r.cmd_reg[CMD_ILR]) begin
         st_nxt.pwr.ilim_sel = ILIM_275;
      end else begin
         st_nxt.pwr.ilim_sel = ILIM_350 + {1'b0,
            st_r.cmd_reg[CMD_ILH], st_r.cmd_reg[CMD_ILL]};
      end

      // Voltage selection, pin honoured only when not ignored
      if (st_r.cmd_reg[CMD_VSPEN]) begin
         st_nxt.pwr.vout_sel = {st_r.ctl_reg[CTL_VTOP],
                                st_r.ctl_reg[CTL_VBOT]};
      end else if (pin_s) begin
         st_nxt.pwr.vout_sel = {1'b1, st_r.ctl_reg[CTL_VTOP]};
      end else begin
         st_nxt.pwr.vout_sel = {1'b0, st_r.ctl_reg[CTL_VBOT]};
      end

      // Bus engine; a start wins even mid-byte, unless power-good is low
      if (start) begin
         st_nxt.bus = S_ADDR;
         st_nxt.cnt = 4'h0;
         st_nxt.sda_oe = 1'b0;
      end else if (stop) begin
         st_nxt.bus = S_IDLE;
         st_nxt.sda_oe = 1'b0;
      end else begin
         case (st_r.bus)
            S_IDLE: begin
               st_nxt.sda_oe = 1'b0;
            end
            S_ADDR: begin
               if (rise) begin
                  st_nxt.sh = {st_r.sh[6:0], sda_s};
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end else if (fall && st_r.cnt == 4'h8) begin
                  if (st_r.sh[7:1] ==
                      {SLV_ADDR_HI, strap_hi_s, strap_lo_s}) begin
                     st_nxt.bus = S_AACK;
                     st_nxt.sda_oe = 1'b1;
                     st_nxt.rw = st_r.sh[0];
                     st_nxt.rd_idx = 2'h0;
                  end else begin
                     st_nxt.bus = S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (fall) begin
                  st_nxt.cnt = 4'h0;
                  if (st_r.rw) begin
                     st_nxt.bus = S_RDAT;
                     st_nxt.sh = rb;
                     st_nxt.sda_oe = ~rb[7];
                     st_nxt.rd_idx = st_r.rd_idx + 2'h1;
                  end else begin
                     st_nxt.bus = S_WDAT;
                     st_nxt.sda_oe = 1'b0;
                  end
               end
            end
            S_WDAT: begin
               if (rise) begin
                  st_nxt.sh = {st_r.sh[6:0], sda_s};
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end else if (fall && st_r.cnt == 4'h8) begin
                  st_nxt.bus = S_WACK;
                  st_nxt.sda_oe = 1'b1;
                  // Only named fields are kept; other bits dropped
                  case (st_r.sh[SEL_MSB:SEL_LSB])
                     SEL_TONE: st_nxt.tone_reg = st_r.sh[4:2];
                     SEL_CMD: st_nxt.cmd_reg = st_r.sh[4:0];
                     SEL_CTL: st_nxt.ctl_reg = {st_r.sh[WR_EN_POS],
                                               st_r.sh[1:0]};
                     default: st_nxt.cmd_reg = st_r.cmd_reg;
                  endcase
               end
            end
            S_WACK: begin
               if (fall) begin
                  st_nxt.sda_oe = 1'b0;
                  st_nxt.bus = S_WDAT;
                  st_nxt.cnt = 4'h0;
               end
            end
            S_RDAT: begin
               if (fall) begin
                  if (st_r.cnt == 4'h7) begin
                     st_nxt.sda_oe = 1'b0;
                     st_nxt.bus = S_RACK;
                  end else begin
                     st_nxt.sh = {st_r.sh[6:0], 1'b0};
                     st_nxt.sda_oe = ~st_r.sh[6];
                     st_nxt.cnt = st_r.cnt + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (rise) begin
                  st_nxt.mack = ~sda_s;
               end else if (fall) begin
                  if (st_r.mack) begin
                     st_nxt.bus = S_RDAT;
                     st_nxt.sh = rb;
                     st_nxt.sda_oe = ~rb[7];
                     st_nxt.cnt = 4'h0;
                     st_nxt.rd_idx = st_r.rd_idx + 2'h1;
                  end else begin
                     st_nxt.bus = S_IDLE;
                  end
               end
            end
            default: begin
               st_nxt.bus = S_IDLE;
               st_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // Without power-good the bus is deaf and registers cleared
      if (!pg_s) begin
         st_nxt.bus = S_IDLE;
         st_nxt.sda_oe = 1'b0;
         st_nxt.tone_reg = TONE_RST;
         st_nxt.cmd_reg = CMD_RST;
         st_nxt.ctl_reg = CTL_RST;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs; data line is open drain, only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_o = st_r.sda_oe;
   assign pwr_o = st_r.pwr;
   assign tone_ch2_o = st_r.tone_out;
   assign tone_detect_level_ch2_o = st_r.det_lvl;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_en_low_off: assert property (!st_r.ctl_reg[CTL_EN] |=>
      !pwr_o.boost_en && !pwr_o.linreg_en)
      else $error("stage enabled while enable bit low");
   a_pg_low_off: assert property (!pg_s ##1 1'b1 |=>
      !pwr_o.boost_en && st_r.bus == S_IDLE)
      else $error("power stage on while power-good low");
   a_ilim_range: assert property (st_r.cmd_reg[CMD_ILR] &&
      st_r.cmd_reg[CMD_ILH] && st_r.cmd_reg[CMD_ILL] |=>
      pwr_o.ilim_sel == ILIM_800)
      else $error("wrong current limit code");
   a_ilim_low: assert property (!st_r.cmd_reg[CMD_ILR] |=>
      pwr_o.ilim_sel == ILIM_275)
      else $error("range zero not at lowest limit");
   // Starts only once reset is gone, as the output lags one cycle
   a_dyn_limit: assert property (rst_n_i |=> pwr_o.dyn_limit_en ==
      !$past(st_r.cmd_reg[CMD_DCL]))
      else $error("dynamic limit follows wrong bit level");
   a_vsel_ignore: assert property (st_r.cmd_reg[CMD_VSPEN] |=>
      pwr_o.vout_sel == $past({st_r.ctl_reg[CTL_VTOP],
                               st_r.ctl_reg[CTL_VBOT]}))
      else $error("ignored pin still affects voltage");
   a_pin_low: assert property (!st_r.cmd_reg[CMD_VSPEN] && !pin_s
      |=> pwr_o.vout_sel[1] == 1'b0)
      else $error("low pin gave top range");
   a_pin_high: assert property (!st_r.cmd_reg[CMD_VSPEN] && pin_s
      |=> pwr_o.vout_sel[1] && pwr_o.vout_sel[0] ==
          $past(st_r.ctl_reg[CTL_VTOP]))
      else $error("high pin gave wrong top voltage");
   a_ext_pass: assert property (st_r.tone_reg[TONE_MSEL] &&
      !st_r.tone_reg[TONE_ENT] |=> tone_ch2_o == $past(ext_s))
      else $error("external tone not passed");
   a_nack_ends: assert property (st_r.bus == S_RACK && !st_r.mack &&
      fall && !start && !stop && pg_s |=> st_r.bus == S_IDLE ##1
      !sda_oe_o)
      else $error("read continued after no-acknowledge");
   a_ack_drive: assert property (st_r.bus == S_AACK |-> sda_oe_o)
      else $error("address acknowledge not driven");

   c_write_ctl: cover property (st_r.bus == S_WDAT && fall &&
      st_r.cnt == 4'h8 && st_r.sh[SEL_MSB:SEL_LSB] == SEL_CTL);
   c_read_more: cover property (st_r.bus == S_RACK && fall && st_r.mack);
   c_read_nack: cover property (st_r.bus == S_RACK && fall && !st_r.mack);
   c_pin_high: cover property (pwr_o.vout_sel == VOUT_19 && pin_s);
endmodule

// >>> verif/dlnb2_host.sv
// Bus master model that clocks the serial register bus
module dlnb2_host (
   input wire logic sys_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Line idle state: clock high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   // Wait a number of rising edges
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // Start, also usable as repeated start: data falls while clock high
   task automatic start_c();
      wt(1);
      scl_o <= 1'b0;
      wt(2);
      sda_oe_o <= 1'b0;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      sda_oe_o <= 1'b1;
      wt(4);
   endtask

   // Stop: data rises while clock high
   task automatic stop_c();
      wt(1);
      scl_o <= 1'b0;
      wt(2);
      sda_oe_o <= 1'b1;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      sda_oe_o <= 1'b0;
      wt(4);
   endtask

   // One bit: data moves mid-low, read mid-high, 4 cycles each phase
   // The 320 ns bit still leaves the slave a cycle of margin
   task automatic bit_x(input logic b, output logic r);
      wt(1);
      scl_o <= 1'b0;
      wt(2);
      sda_oe_o <= ~b;
      wt(2);
      scl_o <= 1'b1;
      wt(2);
      @(negedge sys_clk_i);
      r = sda_i;
      wt(1);
   endtask

   // Byte MSB first, then ninth bit: 1 releases, 0 acknowledges
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
         q[i] = r;
      end
      bit_x(last, r);
      ack = ~r;
   endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench of the channel-2 serial register block
module testbench
   import dlnb2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
   err_total++; $display("Error at %0t: got %h exp %h", $time, a, e); \
   end end

   // ==========================================================
   // Stimulus and wires
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pgood = 1'b1, ext_mod = 1'b0, hv_pin = 1'b0, tx_pin = 1'b0;
   logic [1:0] strap = 2'h0;
   dlnb2_diag_t diag = 7'h00;
   dlnb2_pwr_t pwr;
   logic scl, h_oe, d_oe, d_o, sda, tone, tlvl;
   int err_total = 0;
   int n_checks = 0;

   // Open-drain data wire with pull-up, seen by both parties
   assign sda = ~(h_oe | (d_oe & ~d_o));
   always #20 clk = ~clk;

   dlnb2_regs u_dlnb2_regs (
      .sys_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
      .sda_o(d_o), .sda_oe_o(d_oe), .addr_strap_lo_i(strap[0]),
      .addr_strap_hi_i(strap[1]), .power_ok_i(pgood),
      .ext_mod_in_ch2_i(ext_mod), .hi_volt_pin_ch2_i(hv_pin),
      .tone_tx_pin_ch2_i(tx_pin), .diag_i(diag), .pwr_o(pwr),
      .tone_ch2_o(tone), .tone_detect_level_ch2_o(tlvl));
   dlnb2_host u_dlnb2_host (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl),
      .sda_oe_o(h_oe));

   // ==========================================================
   // Shared tasks; checks land on the falling edge, clear of updates
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr(input logic [1:0] s, input logic [7:0] d,
                     output logic ack);
      logic [7:0] q;
      logic a1, a2;
      u_dlnb2_host.start_c();
      u_dlnb2_host.xfer({SLV_ADDR_HI, s, 1'b0}, 1'b1, q, a1);
      a2 = 1'b0;
      if (a1)
         u_dlnb2_host.xfer(d, 1'b1, q, a2);
      u_dlnb2_host.stop_c();
      tick(6);
      ack = a1 & a2;
   endtask

   task automatic wrc(input logic [7:0] d);
      logic a;
      wr(strap, d, a);
      `CHK(a, 1'b1)
   endtask

   // Reads five bytes, acknowledging all but the last
   task automatic rd(output logic [7:0] q [5], output logic a);
      logic x;
      u_dlnb2_host.start_c();
      u_dlnb2_host.xfer({SLV_ADDR_HI, strap, 1'b1}, 1'b1, q[0], a);
      for (int i = 0; i < 5; i++)
         u_dlnb2_host.xfer(8'hff, i == 4, q[i], x);
      u_dlnb2_host.stop_c();
      tick(2);
   endtask

   // Tone edges over two internal half periods
   task automatic edges(output int n);
      logic p;
      @(negedge clk);
      p = tone;
      n = 0;
      repeat (2 * TONE_HALF) begin
         @(negedge clk);
         if (tone !== p)
            n++;
         p = tone;
      end
   endtask

   // ==========================================================
   // Scenarios
   // Cleared limit bit means dynamic limiting is on from reset
   task automatic t_reset();
      `CHK(pwr, 8'h01)
      `CHK({d_oe, tone, tlvl}, 3'h0)
   endtask

   task automatic t_addr();
      logic a;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk) strap <= 2'(s);
         wr(2'(s), {SEL_CTL, 5'h00}, a);
         `CHK(a, 1'b1)
         wr(2'(s) ^ 2'h1, {SEL_CTL, 5'h00}, a);
         `CHK(a, 1'b0)
      end
   endtask

   task automatic t_cmd();
      logic [2:0] e;
      for (int i = 0; i < 8; i++) begin
         wrc({SEL_CMD, i[0], 1'b1, i[2:0]});
         e = i[2] ? 3'(i[1:0] + 1) : ILIM_275;
         `CHK(pwr.ilim_sel, e)
         `CHK(pwr.dyn_limit_en, ~i[0])
      end
   endtask

   // Bit 3 ignores the pin, bit 2 is the pin, bits 1:0 top/bottom
   task automatic t_volt();
      logic [1:0] e;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk) hv_pin <= i[2];
         wrc({SEL_CMD, 1'b0, i[3], 3'h0});
         wrc({SEL_CTL, 1'b1, 2'h3, i[1:0]});
         e = i[3] ? 2'(i[1:0]) : {i[2], i[2] ? i[1] : i[0]};
         `CHK(pwr.vout_sel, e)
         `CHK({pwr.boost_en, pwr.linreg_en}, 2'h3)
      end
      wrc({SEL_CTL, 5'h03});
      `CHK({pwr.boost_en, pwr.linreg_en}, 2'h0)
   endtask

   task automatic t_tone();
      int n;
      // External tone passes through; threshold bit picks level
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) ext_mod <= i[1];
         wrc({SEL_TONE, 2'b01, i[0], 2'h0});
         `CHK(tlvl, i[0])
         `CHK(tone, i[1])
      end
      wrc({3'h4, 5'h00});
      `CHK({tone, tlvl}, 2'h3)
      @(posedge clk) ext_mod <= 1'b0;
      wrc({SEL_TONE, 5'h00});
      edges(n);
      `CHK(n, 0)
      @(posedge clk) tx_pin <= 1'b1;
      tick(6);
      `CHK(tlvl, 1'b1)
      @(posedge clk) begin
         ext_mod <= 1'b1;
         tx_pin <= 1'b0;
      end
      tick(8);
      edges(n);
      `CHK(n, 2)
      @(posedge clk) ext_mod <= 1'b0;
      wrc({SEL_TONE, 3'b100, 2'h3});
      edges(n);
      `CHK(n, 2)
   endtask

   task automatic t_read();
      logic a;
      logic [7:0] q [5];
      wrc({SEL_TONE, 3'b011, 2'h3});
      wrc({SEL_CMD, 5'h15});
      wrc({SEL_CTL, 5'h1d});
      @(posedge clk) diag <= 7'h55;
      rd(q, a);
      `CHK(a, 1'b1)
      `CHK(q[0], {SEL_TONE, 5'h0c})
      `CHK(q[1], {SEL_CMD, 5'h15})
      `CHK(q[2], {SEL_CTL, 5'h11})
      `CHK(q[3], 8'h55)
      `CHK(q[4], {SEL_TONE, 5'h0c})
      `CHK(d_oe, 1'b0)
   endtask

   task automatic t_pgood();
      logic a;
      logic [7:0] q [5];
      wrc({SEL_CTL, 5'h13});
      // Pin low too, so the cleared registers give the lowest output
      @(posedge clk) begin
         pgood <= 1'b0;
         hv_pin <= 1'b0;
      end
      tick(6);
      `CHK(pwr, 8'h01)
      wr(strap, {SEL_CTL, 5'h13}, a);
      `CHK(a, 1'b0)
      `CHK(pwr, 8'h01)
      @(posedge clk) pgood <= 1'b1;
      tick(6);
      rd(q, a);
      `CHK(a, 1'b1)
      `CHK(q[0], {SEL_TONE, 5'h00})
      `CHK(q[1], {SEL_CMD, 5'h00})
      `CHK(q[2], {SEL_CTL, 5'h00})
      wrc({SEL_CTL, 5'h13});
      `CHK(pwr.boost_en, 1'b1)
   endtask

   // ==========================================================
   // Verdict, reached by the main sequence or the watchdog
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence after a three-cycle reset
   initial begin
      tick(2);
      @(posedge clk) rst_n <= 1'b1;
      tick(4);
      t_reset();
      t_addr();
      t_cmd();
      t_volt();
      t_tone();
      t_read();
      t_pgood();
      wrap_up();
   end

   // Watchdog, about 2.1 times the expected run length
   initial begin
      repeat (32000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule
